// ===== hw/msm_boot_loader.sv
`timescale 1ns/10ps
`default_nettype none
module msm_boot_loader
#(
   parameter logic [10:0] DIV_FAST  = 11'd256,
   parameter logic [10:0] DIV_SLOW  = 11'd1664,
   parameter logic [10:0] DIV_ALT_A = 11'd208,
   parameter logic [10:0] DIV_ALT_B = 11'd384,
   parameter logic [7:0]  SYNC_SLOW = 8'h00
)
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic        go,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   output logic [10:0]      sci_div,
   output logic             ram_we,
   output logic [15:0]      ram_waddr,
   output logic [7:0]       ram_wdata,
   output logic             load_done,
   output logic             jump_pulse
);
   msm_pkg::msm_ld_state_t state_reg, state_next;
   logic [10:0] count_reg;
   logic [19:0] idle_reg;
   logic [7:0]  tmo_reg;
   logic [19:0] tmo_limit;
   logic        hit_fast, hit_slow, hit_a, hit_b, sync_ok;
   logic        timed_out, full;
   logic        take;

   assign hit_fast  = rx_data == msm_pkg::SYNC_FAST;
   assign hit_slow  = rx_data == SYNC_SLOW;
   assign hit_a     = rx_data == msm_pkg::SYNC_ALT_A;
   assign hit_b     = rx_data == msm_pkg::SYNC_ALT_B;
   assign sync_ok   = hit_fast | hit_slow | hit_a | hit_b;
   assign tmo_limit = 20'(tmo_reg * sci_div);
   assign timed_out = idle_reg >= tmo_limit;
   assign full      = count_reg == msm_pkg::LOAD_MAX;
   assign take      = state_reg == msm_pkg::MSM_LD_LOAD && rx_valid && !full;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         msm_pkg::MSM_LD_IDLE: if (go) state_next = msm_pkg::MSM_LD_SYNC;
         msm_pkg::MSM_LD_SYNC:
            if (rx_valid && sync_ok) state_next = msm_pkg::MSM_LD_LOAD;
         msm_pkg::MSM_LD_LOAD:
            if ((full || timed_out) && !tx_valid)
               state_next = msm_pkg::MSM_LD_DONE;
         msm_pkg::MSM_LD_DONE: state_next = msm_pkg::MSM_LD_DONE;
         default: state_next = msm_pkg::MSM_LD_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_reg  <= msm_pkg::MSM_LD_IDLE;
         count_reg  <= '0;
         idle_reg   <= '0;
         tmo_reg    <= msm_pkg::TMO_STD;
         sci_div    <= DIV_FAST;
         tx_valid   <= 1'b0;
         tx_data    <= '0;
         ram_we     <= 1'b0;
         ram_waddr  <= msm_pkg::LOAD_ADDR;
         ram_wdata  <= '0;
         jump_pulse <= 1'b0;
      end
      else if (ce)
      begin
         state_reg  <= state_next;
         ram_we     <= take;
         jump_pulse <= state_reg == msm_pkg::MSM_LD_LOAD
                       && state_next == msm_pkg::MSM_LD_DONE;
         // rate and timeout from sync value
         if (state_reg == msm_pkg::MSM_LD_SYNC && rx_valid && sync_ok)
         begin
            sci_div <= hit_a ? DIV_ALT_A : hit_b ? DIV_ALT_B :
                       hit_fast ? DIV_FAST : DIV_SLOW;
            tmo_reg <= hit_a ? msm_pkg::TMO_ALT_A :
                       hit_b ? msm_pkg::TMO_ALT_B : msm_pkg::TMO_STD;
         end
         if (take || state_reg != msm_pkg::MSM_LD_LOAD)
            idle_reg <= '0;
         else if (!timed_out)
            idle_reg <= idle_reg + 20'd1;
         if (take)
         begin
            ram_wdata <= rx_data;
            ram_waddr <= 16'(msm_pkg::LOAD_ADDR + count_reg);
            count_reg <= count_reg + 11'd1;
            tx_data   <= rx_data;
            tx_valid  <= 1'b1;
         end
         else if (tx_ready)
            tx_valid <= 1'b0;
      end
   end

   assign load_done = state_reg == msm_pkg::MSM_LD_DONE;
endmodule
`default_nettype wire

// ===== hw/msm_mode_map.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Mode pins sampled during reset fix mode
// - Single chip: ports stay general-purpose I/O
// - Expanded: address on B/F, data C, R/W
// - Bootstrap enables boot ROM, reset vector there
// - Up to 1024 bytes stored from 0080, echoed
// - Load ends on idle (four characters for sync FF or 00) or 1024
// - After loading, execution jumps to 0080
// - Loader makes port D open-drain; pull-up outside
// - Bootstrap non-reset vectors resolve into RAM jump table
// - Sync value selects baud rate and timeout
// - Register block at 0000, movable per 4k
// - RAM at 0080 default, movable per 4k
// - Shared page: RAM x080, hidden bytes x400-x47F
// - RAM and register pages from separate nibbles
// - Enabled EEPROM at 0D80, movable to xD80
// - Program ROM present only while enable set
// - Test mode clears the ROM enable
// - Single chip forces ROM to 8000-FFFF
// - Expanded placement zero maps ROM 0000-7FFF
// - Boot ROM decodes 512 bytes, supplies vectors
// - On-chip decode same in expanded, single chip, except ROM placement
// - Boot ROM disabled outside bootstrap mode
// - Expanded/test: port C is data at reset
module msm_mode_map
#(
   parameter logic [7:0]  MODE_TABLE = msm_pkg::MODE_TABLE_DEF,
   parameter logic [10:0] DIV_FAST   = 11'd256,
   parameter logic [10:0] DIV_SLOW   = 11'd1664,
   parameter logic [10:0] DIV_ALT_A  = 11'd208,
   parameter logic [10:0] DIV_ALT_B  = 11'd384,
   parameter logic [7:0]  SYNC_SLOW  = 8'h00
)
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic        mode_pin_b,
   input  wire logic        mode_pin_a,
   input  wire logic        cfg_rom_enable,
   input  wire logic        cfg_rom_placement,
   input  wire logic        cfg_eeprom_enable,
   input  wire logic [7:0]  init_map,
   input  wire logic [3:0]  eeprom_remap,
   input  wire logic        cpu_valid,
   input  wire logic        cpu_rw,
   input  wire logic [15:0] cpu_addr,
   input  wire logic [7:0]  cpu_wdata,
   output logic [1:0]       op_mode,
   output logic             sel_regs,
   output logic             sel_ram,
   output logic             sel_eeprom,
   output logic             sel_rom,
   output logic             sel_boot,
   output logic             sel_ext,
   output logic [14:0]      local_index,
   output logic             vec_hit,
   output logic [7:0]       vec_data,
   output logic [7:0]       ext_rdata,
   input  wire logic [7:0]  gpb_out,
   input  wire logic [7:0]  gpb_oe,
   input  wire logic [7:0]  gpc_out,
   input  wire logic [7:0]  gpc_oe,
   input  wire logic [7:0]  gpf_out,
   input  wire logic [7:0]  gpf_oe,
   input  wire logic        gprw_out,
   input  wire logic        gprw_oe,
   output logic [7:0]       pb_o,
   output logic [7:0]       pb_oe,
   output logic [7:0]       pf_o,
   output logic [7:0]       pf_oe,
   output logic [7:0]       pc_o,
   output logic [7:0]       pc_oe,
   input  wire logic [7:0]  pc_i,
   output logic             rw_o,
   output logic             rw_oe,
   output logic             pd_wired_or,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   output logic [10:0]      sci_div,
   output logic             ram_we,
   output logic [15:0]      ram_waddr,
   output logic [7:0]       ram_wdata,
   output logic             load_done,
   output logic             jump_pulse,
   output logic [15:0]      jump_addr
);
   msm_pkg::msm_mode_t mode_reg;
   logic [1:0]  pin_meta_reg, pin_sync_reg;
   logic [7:0]  pc_meta_reg, pc_sync_reg;
   logic [1:0]  pin_mode;
   logic        is_boot, is_test, is_single, bus_mode;
   logic [3:0]  reg_page, ram_page;
   logic [11:0] ofs;
   logic        same_page;
   logic        reg_hit, ram_hit, ee_hit, rom_hit, boot_hit, vec_area;
   logic        rom_on, rom_high;
   logic [9:0]  ram_idx, ee_idx;
   logic [8:0]  boot_idx;
   logic [15:0] ram_start, vec_target;
   logic [4:0]  vec_idx;
   logic        ext_cycle, onchip;

   // Pins pass two flops; only the second stage is read
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         pin_meta_reg <= {mode_pin_b, mode_pin_a};
         pin_sync_reg <= pin_meta_reg;
         pc_meta_reg  <= pc_i;
         pc_sync_reg  <= pc_meta_reg;
      end
   end

   // table lookup of the pin pair
   assign pin_mode = MODE_TABLE[{pin_sync_reg, 1'b0} +: 2];

   // mode follows the pins while reset is held, then stays
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         mode_reg <= msm_pkg::msm_mode_t'(pin_mode);
   end

   assign op_mode   = mode_reg;
   assign is_boot   = mode_reg == msm_pkg::MSM_MODE_BOOT;
   assign is_test   = mode_reg == msm_pkg::MSM_MODE_TEST;
   assign is_single = mode_reg == msm_pkg::MSM_MODE_SINGLE;
   // expanded and test drive the bus straight from reset
   assign bus_mode  = mode_reg == msm_pkg::MSM_MODE_EXPANDED || is_test;

   // separate nibbles for RAM and registers
   assign ram_page  = init_map[7:4];
   assign reg_page  = init_map[3:0];
   assign ofs       = cpu_addr[11:0];
   assign same_page = ram_page == reg_page;

   // register block on its 4k page
   assign reg_hit = cpu_addr[15:12] == reg_page && ofs <= msm_pkg::REG_BLOCK_END;

   // shared page shifts RAM and mirrors the hidden bytes
   assign ram_hit = cpu_addr[15:12] == ram_page
                    && (same_page ? ofs <= msm_pkg::RAM_SHARED_END
                                  : ofs[11:10] == 2'b00);
   assign ram_idx = cpu_addr[9:0];
   assign ram_start = {ram_page,
                       same_page ? msm_pkg::RAM_SHARED_OFS : 12'h000};

   // EEPROM at xD80 of the remap page when enabled
   assign ee_hit = cfg_eeprom_enable && cpu_addr[15:12] == eeprom_remap
                   && ofs >= msm_pkg::EE_PAGE_OFS;
   assign ee_idx = 10'(ofs - msm_pkg::EE_PAGE_OFS);

   // ROM only while enabled, never in test mode
   assign rom_on   = cfg_rom_enable && !is_test;
   // single chip forces the high placement
   assign rom_high = is_single | cfg_rom_placement;
   assign rom_hit  = rom_on && (cpu_addr[15] == rom_high);

   // 512-byte boot block, vector area redirected into it
   assign vec_area = cpu_addr[15:6] == msm_pkg::VEC_AREA_HI;
   // boot ROM decodes only in bootstrap mode
   assign boot_hit = is_boot
                     && (cpu_addr[15:9] == msm_pkg::BOOT_BLOCK_HI || vec_area);
   assign boot_idx = vec_area ? (msm_pkg::BOOT_VEC_OFS | {3'b000, ofs[5:0]})
                              : cpu_addr[8:0];

   // non-reset vectors point into a RAM jump table
   assign vec_idx    = cpu_addr[5:1];
   assign vec_target = (vec_idx == msm_pkg::VEC_RESET_IDX)
                       ? msm_pkg::BOOT_ENTRY
                       : 16'(ram_start + msm_pkg::VEC_JT_END
                             - 16'(3 * (msm_pkg::VEC_RESET_IDX - vec_idx)));
   // reset vector comes from the boot ROM
   assign vec_hit  = cpu_valid && is_boot && vec_area;
   assign vec_data = cpu_addr[0] ? vec_target[7:0] : vec_target[15:8];

   // fixed priority, same in every mode; in expanded and test the rest goes out
   assign onchip     = reg_hit | ram_hit | boot_hit | ee_hit | rom_hit;
   assign sel_regs   = cpu_valid && reg_hit;
   assign sel_ram    = cpu_valid && !reg_hit && ram_hit;
   assign sel_boot   = cpu_valid && !reg_hit && !ram_hit && boot_hit;
   assign sel_eeprom = cpu_valid && !reg_hit && !ram_hit && !boot_hit
                       && ee_hit;
   assign sel_rom    = cpu_valid && !reg_hit && !ram_hit && !boot_hit
                       && !ee_hit && rom_hit;
   assign ext_cycle  = cpu_valid && bus_mode && !onchip;
   assign sel_ext    = ext_cycle;

   assign local_index = sel_regs   ? {8'h00, cpu_addr[6:0]} :
                        sel_ram    ? {5'h00, ram_idx} :
                        sel_boot   ? {6'h00, boot_idx} :
                        sel_eeprom ? {5'h00, ee_idx} :
                        cpu_addr[14:0];

   assign ext_rdata = pc_sync_reg;

   // pin drivers; registered so pins see no decode glitches
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pb_o  <= '0;
         pb_oe <= '0;
         pf_o  <= '0;
         pf_oe <= '0;
         pc_o  <= '0;
         pc_oe <= '0;
         rw_o  <= 1'b1;
         rw_oe <= 1'b0;
      end
      else if (ce)
      begin
         if (bus_mode)
         begin
            // high byte on B, low on F, data on C
            pb_o  <= cpu_addr[15:8];
            pb_oe <= 8'hFF;
            pf_o  <= cpu_addr[7:0];
            pf_oe <= 8'hFF;
            pc_o  <= cpu_wdata;
            pc_oe <= {8{ext_cycle && !cpu_rw}};
            rw_o  <= !(ext_cycle && !cpu_rw);
            rw_oe <= 1'b1;
         end
         else
         begin
            pb_o  <= gpb_out;
            pb_oe <= gpb_oe;
            pf_o  <= gpf_out;
            pf_oe <= gpf_oe;
            pc_o  <= gpc_out;
            pc_oe <= gpc_oe;
            rw_o  <= gprw_out;
            rw_oe <= gprw_oe;
         end
      end
   end

   // open-drain port D while the loader owns it
   assign pd_wired_or = is_boot;

   // entry point once the download ends
   assign jump_addr = msm_pkg::LOAD_ADDR;

   msm_boot_loader
   #(
      .DIV_FAST  (DIV_FAST),
      .DIV_SLOW  (DIV_SLOW),
      .DIV_ALT_A (DIV_ALT_A),
      .DIV_ALT_B (DIV_ALT_B),
      .SYNC_SLOW (SYNC_SLOW)
   )
   u_loader
   (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .ce         (ce),
      .go         (is_boot),
      .rx_valid   (rx_valid),
      .rx_data    (rx_data),
      .tx_ready   (tx_ready),
      .tx_valid   (tx_valid),
      .tx_data    (tx_data),
      .sci_div    (sci_div),
      .ram_we     (ram_we),
      .ram_waddr  (ram_waddr),
      .ram_wdata  (ram_wdata),
      .load_done  (load_done),
      .jump_pulse (jump_pulse)
   );
endmodule
`default_nettype wire

// ===== shared/msm_pkg.sv
package msm_pkg;

   // Operating modes
   typedef enum logic [1:0]
   {
      MSM_MODE_SINGLE   = 2'b00,
      MSM_MODE_EXPANDED = 2'b01,
      MSM_MODE_BOOT     = 2'b10,
      MSM_MODE_TEST     = 2'b11
   } msm_mode_t;

   // Loader sequencer states
   typedef enum logic [1:0]
   {
      MSM_LD_IDLE = 2'b00,
      MSM_LD_SYNC = 2'b01,
      MSM_LD_LOAD = 2'b10,
      MSM_LD_DONE = 2'b11
   } msm_ld_state_t;

   // Pin pair {b,a} to mode, two bits per entry, entry 0 in the low bits
   localparam logic [7:0]  MODE_TABLE_DEF = 8'h4E;

   // Address map
   localparam logic [11:0] REG_BLOCK_END  = 12'h07F;
   localparam logic [11:0] RAM_SHARED_END = 12'h47F;
   localparam logic [11:0] RAM_SHARED_OFS = 12'h080;
   localparam logic [11:0] EE_PAGE_OFS    = 12'hD80;
   localparam logic [6:0]  BOOT_BLOCK_HI  = 7'h5F;
   localparam logic [15:0] BOOT_ENTRY     = 16'hBE40;
   localparam logic [9:0]  VEC_AREA_HI    = 10'h3FF;
   localparam logic [15:0] VEC_JT_END     = 16'h00FD;
   localparam logic [4:0]  VEC_RESET_IDX  = 5'h1F;
   localparam logic [8:0]  BOOT_VEC_OFS   = 9'h1C0;

   // Loader
   localparam logic [15:0] LOAD_ADDR      = 16'h0080;
   localparam logic [10:0] LOAD_MAX       = 11'h400;
   localparam logic [7:0]  SYNC_FAST      = 8'hFF;
   localparam logic [7:0]  SYNC_ALT_A     = 8'hF0;
   localparam logic [7:0]  SYNC_ALT_B     = 8'hFD;
   // Timeouts in tenths of a character time
   localparam logic [7:0]  TMO_STD        = 8'h28;
   localparam logic [7:0]  TMO_ALT_A      = 8'h31;
   localparam logic [7:0]  TMO_ALT_B      = 8'hAD;

endpackage

// ===== sim/msm_ext_mem.sv
`timescale 1ns/10ps
`default_nettype none
module msm_ext_mem
(
   input  wire logic       clk,
   input  wire logic [7:0] addr_lo,
   input  wire logic [7:0] pc_o,
   input  wire logic [7:0] pc_oe,
   input  wire logic       rw_o,
   input  wire logic       rw_oe,
   output logic      [7:0] pc_i
);
   // Partial decode on the low byte only, like a small peripheral
   logic [7:0] mem [256];
   logic [7:0] last = 8'h5A;

   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
   end

   always @(posedge clk)
   begin
      if (rw_oe && !rw_o && pc_oe == 8'hFF)
         mem[addr_lo] <= pc_o;
      last <= pc_i;
   end

   // answer on reads; a released bus never repeats its last value
   assign pc_i = (pc_oe == 8'hFF) ? pc_o :
                 (rw_oe && rw_o) ? mem[addr_lo] : ~last;
endmodule
`default_nettype wire

// ===== sim/msm_mode_map_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module msm_mode_map_asserts
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        ce,
   input wire logic        cpu_valid,
   input wire logic        cpu_rw,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0]  cpu_wdata,
   input wire logic [7:0]  init_map,
   input wire logic [1:0]  op_mode,
   input wire logic        sel_regs,
   input wire logic        sel_ram,
   input wire logic        sel_eeprom,
   input wire logic        sel_rom,
   input wire logic        sel_boot,
   input wire logic        sel_ext,
   input wire logic [7:0]  pb_o,
   input wire logic [7:0]  pf_o,
   input wire logic [7:0]  pc_o,
   input wire logic [7:0]  pc_oe,
   input wire logic        rw_o,
   input wire logic        pd_wired_or,
   input wire logic        ram_we,
   input wire logic [15:0] ram_waddr,
   input wire logic [7:0]  ram_wdata,
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        jump_pulse,
   input wire logic [15:0] jump_addr
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   wire boot_m   = (op_mode == msm_pkg::MSM_MODE_BOOT);
   wire single_m = (op_mode == msm_pkg::MSM_MODE_SINGLE);
   wire test_m   = (op_mode == msm_pkg::MSM_MODE_TEST);

   property p_boot_off;
      !boot_m |-> !sel_boot;
   endproperty
   a_boot_off: assert property (p_boot_off) else $error("boot sel");
   property p_no_ext;
      (single_m || boot_m) |-> !sel_ext;
   endproperty
   a_no_ext: assert property (p_no_ext) else $error("ext sel");
   property p_onehot;
      $onehot0({sel_regs, sel_ram, sel_eeprom, sel_rom, sel_boot, sel_ext});
   endproperty
   a_onehot: assert property (p_onehot) else $error("two sels");
   property p_regs;
      cpu_valid && cpu_addr[15:12] == init_map[3:0]
         && cpu_addr[11:0] <= 12'h07F |-> sel_regs;
   endproperty
   a_regs: assert property (p_regs) else $error("regs miss");
   property p_rom_test;
      test_m |-> !sel_rom;
   endproperty
   a_rom_test: assert property (p_rom_test) else $error("rom in test");
   property p_rom_single;
      single_m && sel_rom |-> cpu_addr[15];
   endproperty
   a_rom_single: assert property (p_rom_single) else $error("rom low");
   property p_ext_addr;
      ce && cpu_valid && sel_ext |=> pb_o == $past(cpu_addr[15:8])
         && pf_o == $past(cpu_addr[7:0]);
   endproperty
   a_ext_addr: assert property (p_ext_addr) else $error("ext addr");
   property p_ext_wr;
      ce && cpu_valid && sel_ext && !cpu_rw |=> pc_oe == 8'hFF && !rw_o
         && pc_o == $past(cpu_wdata);
   endproperty
   a_ext_wr: assert property (p_ext_wr) else $error("ext write");
   property p_pd;
      pd_wired_or == boot_m;
   endproperty
   a_pd: assert property (p_pd) else $error("port D drive");
   property p_echo;
      ram_we |-> tx_valid && tx_data == ram_wdata
         && ram_waddr inside {[16'h0080:16'h047F]};
   endproperty
   a_echo: assert property (p_echo) else $error("echo");
   property p_jump;
      jump_pulse |-> jump_addr == 16'h0080 ##1 !jump_pulse;
   endproperty
   a_jump: assert property (p_jump) else $error("jump");
endmodule
`default_nettype wire

// ===== sim/tb_msm_mode_map.sv
`timescale 1ns/10ps
`default_nettype none
module tb_msm_mode_map;
   logic        clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, cpu_valid = 1'b1;
   logic        mode_pin_b = 1'b0, mode_pin_a = 1'b0, cpu_rw = 1'b1;
   logic        cfg_rom_enable = 1'b1, cfg_rom_placement = 1'b1;
   logic        cfg_eeprom_enable = 1'b1, gprw_out = 1'b0, gprw_oe = 1'b0;
   logic        rx_valid = 1'b0, tx_ready = 1'b0;
   logic [3:0]  eeprom_remap = 4'h0;
   logic [7:0]  init_map = 8'h00, cpu_wdata = 8'h00, rx_data = 8'h00;
   logic [7:0]  gpb_out = 8'h00, gpb_oe = 8'h00, gpc_out = 8'h00;
   logic [7:0]  gpc_oe = 8'h00, gpf_out = 8'h00, gpf_oe = 8'h00, pc_i;
   logic [15:0] cpu_addr = 16'h0000, rnd = 16'h001B, v;
   logic        sel_regs, sel_ram, sel_eeprom, sel_rom, sel_boot, sel_ext;
   logic        vec_hit, rw_o, rw_oe, pd_wired_or, tx_valid, ram_we;
   logic        load_done, jump_pulse;
   logic [1:0]  op_mode, em;
   logic [5:0]  e;
   logic [7:0]  vec_data, ext_rdata, pb_o, pb_oe, pf_o, pf_oe, pc_o, pc_oe;
   logic [7:0]  tx_data, ram_wdata;
   logic [10:0] sci_div;
   logic [14:0] local_index;
   logic [15:0] ram_waddr, jump_addr;
   logic [7:0]  syncs [4] = '{8'hFF, 8'hF0, 8'hFD, 8'h00};
   int          divs [4] = '{4, 3, 6, 26};
   int          tmos [4] = '{40, 49, 173, 40};
   logic [15:0] corner [10] = '{16'h007F, 16'h0080, 16'h047F, 16'h0480,
      16'h0D80, 16'hBE40, 16'hBFFF, 16'hFFFE, 16'h7FFF, 16'h8000};
   int          fails = 0, n_compared = 0, cycles = 0, cnt, t;

   // Short dividers keep the idle timeouts to at most 1040 cycles
   msm_mode_map
   #(
      .DIV_FAST(11'h004), .DIV_SLOW(11'h01A),
      .DIV_ALT_A(11'h003), .DIV_ALT_B(11'h006)
   )
   msm_mode_map_inst
   (
      .*
   );

   msm_ext_mem msm_ext_mem_inst
   (
      .clk(clk), .addr_lo(pf_o), .pc_o(pc_o), .pc_oe(pc_oe),
      .rw_o(rw_o), .rw_oe(rw_oe), .pc_i(pc_i)
   );

   always #2 clk = ~clk;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Expected {regs,ram,eeprom,rom,boot,ext}; priority is regs, ram, boot, eeprom, rom, ext
   function automatic logic [5:0] exp_sel(input logic [1:0] m,
                                          input logic [15:0] a);
      logic pg;
      pg = (init_map[7:4] == init_map[3:0]);
      if (a[15:12] == init_map[3:0] && a[11:0] <= 12'h07F)
         return 6'h20;
      if (a[15:12] == init_map[7:4] && a[11:0] <= (pg ? 12'h47F : 12'h3FF))
         return 6'h10;
      if (m == msm_pkg::MSM_MODE_BOOT && (a[15:9] == 7'h5F
          || a[15:6] == 10'h3FF))
         return 6'h02;
      if (cfg_eeprom_enable && a[15:12] == eeprom_remap
          && a[11:0] >= 12'hD80)
         return 6'h08;
      if (cfg_rom_enable && m != msm_pkg::MSM_MODE_TEST
          && a[15] == (m == msm_pkg::MSM_MODE_SINGLE || cfg_rom_placement))
         return 6'h04;
      return m[0] ? 6'h01 : 6'h00;
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] pins);
      @(negedge clk);
      {mode_pin_b, mode_pin_a} = pins;
      sys_rst = 1'b1;
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      @(negedge clk);
   endtask

   task automatic send_byte(input logic [7:0] d);
      rx_data = d;
      rx_valid = 1'b1;
      @(negedge clk);
      rx_valid = 1'b0;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         finish_test();
      end
   end

   initial
   begin
      for (int p = 0; p < 4; p++)
      begin
         em = msm_pkg::MODE_TABLE_DEF[2*p +: 2];
         do_reset(p[1:0]);
         check("op_mode", 32'(op_mode), 32'(em));
         rnd = lfsr(rnd);
         {gpb_out, gpb_oe} = rnd;
         {gpf_out, gpf_oe} = ~rnd;
         @(negedge clk);
         check("pb_oe", 32'(pb_oe), em[0] ? 32'h00FF : 32'(gpb_oe));
         check("pf_oe", 32'(pf_oe), em[0] ? 32'h00FF : 32'(gpf_oe));
         for (int i = 0; i < 210; i++)
         begin
            rnd = lfsr(rnd);
            if (i >= 10)
               {init_map, eeprom_remap, cfg_rom_enable, cfg_rom_placement,
                cfg_eeprom_enable} = rnd[14:0];
            rnd = lfsr(rnd);
            cpu_addr = (i < 10) ? corner[i] : rnd;
            cpu_valid = (i < 10) || rnd[2];
            cpu_rw = rnd[3];
            cpu_wdata = rnd[11:4];
            #1;
            e = cpu_valid ? exp_sel(em, cpu_addr) : 6'h00;
            check("sel", 32'({sel_regs, sel_ram, sel_eeprom, sel_rom,
               sel_boot, sel_ext}), 32'(e));
            check("index", 32'(local_index), 32'(e[5] ? cpu_addr[6:0] :
               e[4] ? cpu_addr[9:0] : e[3] ? cpu_addr[11:0] - 12'hD80 :
               (e[1] && cpu_addr[15:6] == 10'h3FF) ? 9'h1C0 + cpu_addr[5:0] :
               e[1] ? cpu_addr[8:0] : cpu_addr[14:0]));
            @(negedge clk);
         end
         {init_map, eeprom_remap} = 12'h000;
         {cfg_rom_enable, cfg_rom_placement, cfg_eeprom_enable} = 3'h7;
         cpu_valid = 1'b1;
         if (em == msm_pkg::MSM_MODE_EXPANDED)
         begin
            cpu_addr = 16'h2A5C;
            cpu_rw = 1'b0;
            cpu_wdata = 8'hC3;
            @(negedge clk);
            check("bus", 32'({pb_o, pf_o, pc_o, rw_o}), 32'h0054_B986);
            cpu_rw = 1'b1;
            repeat (4) @(negedge clk);
            check("ext_rdata", 32'(ext_rdata), 32'h0000_00C3);
            // Clock enable low must freeze pins and read synchroniser
            ce = 1'b0;
            cpu_addr = 16'h1234;
            repeat (2) @(negedge clk);
            check("ce_hold", 32'({pb_o, ext_rdata}), 32'h0000_2AC3);
            ce = 1'b1;
         end
         $display("mode test %0d done", p);
      end
      for (int s = 0; s < 4; s++)
      begin
         // Pins 00 select bootstrap in the default table
         do_reset(2'b00);
         send_byte(syncs[s]);
         check("sci_div", 32'(sci_div), 32'(divs[s]));
         @(negedge clk);
         for (int n = 0; n < ((s == 0) ? 1024 : 3); n++)
         begin
            rnd = lfsr(rnd);
            send_byte(rnd[7:0]);
            check("ram", 32'({ram_we, ram_wdata, ram_waddr}),
               32'({1'b1, rnd[7:0], 16'h0080 + 16'(n)}));
            check("echo", 32'({tx_valid, tx_data}), 32'({1'b1, rnd[7:0]}));
            tx_ready = 1'b1;
            @(negedge clk);
            tx_ready = 1'b0;
         end
         cnt = 0;
         while (load_done !== 1'b1 && cnt < 2000)
         begin
            @(negedge clk);
            cnt++;
         end
         t = (s == 0) ? 0 : tmos[s] * divs[s];
         check("load_wait", 32'(cnt >= t - 4 && cnt <= t + 4), 32'h1);
         check("jump", 32'({jump_pulse, jump_addr}), 32'h0001_0080);
         send_byte(8'h55);
         check("late_byte", 32'(ram_we), 32'h0);
         $display("loader test %0d done", s);
      end
      for (int i = 0; i < 32; i++)
      begin
         v = (i == 31) ? 16'hBE40 : 16'h0080 + 16'h00FD - 16'(3 * (31 - i));
         cpu_addr = 16'hFFC0 + 16'(2 * i);
         #1 check("vec_hi", 32'({vec_hit, vec_data}), 32'({1'b1, v[15:8]}));
         cpu_addr = cpu_addr + 16'h0001;
         #1 check("vec_lo", 32'({vec_hit, vec_data}), 32'({1'b1, v[7:0]}));
         @(negedge clk);
      end
      $display("vector test done");
      finish_test();
   end
endmodule

bind msm_mode_map msm_mode_map_asserts msm_mode_map_asserts_inst (.*);
`default_nettype wire
